// *** verilog/aewc_pkg.sv ***
// Constants and types for the absolute encoder width configuration block.
// What this block does
// - The width word is used only for axis types 47 and 48, else ignored.
// - For type 47 the total position bit count is word bits 7 to 0.
// - For type 47 the multi-turn bit count is word bits 14 to 8.
// - For type 48 the position bit count is word bits 5 to 0.
// - The raw position is shown with the programmed bit count, capped at POS_W bits.
// - For type 48, word bit 6 selects the coding; a one is plain binary.
package aewc_pkg;

    // ************************************************************
    // Register map, byte addresses on the APB bus.
    // ************************************************************
    localparam logic [7:0] ADDR_WIDTH_CFG = 8'h00;
    localparam logic [7:0] ADDR_AXIS_TYPE = 8'h04;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_POSITION  = 8'h0C;
    localparam logic [7:0] ADDR_TURNS     = 8'h10;

    // ************************************************************
    // Axis type codes that use the width word.
    // ************************************************************
    localparam logic [7:0] TYPE_BIDIR_ABS = 8'h2F;
    localparam logic [7:0] TYPE_SYNC_ABS  = 8'h30;

    // ************************************************************
    // Field positions inside the width word and the status word.
    // ************************************************************
    localparam int CFG_W        = 15;
    localparam int TOTAL_LSB    = 0;
    localparam int TOTAL_W      = 8;
    localparam int MTURN_LSB    = 8;
    localparam int MTURN_W      = 7;
    localparam int SYNC_BITS_W  = 6;
    localparam int SYNC_BIN_BIT = 6;
    localparam int STAT_BIN_BIT = 16;
    localparam int STAT_MODE_LSB = 24;

    // ************************************************************
    // Values after reset.
    // ************************************************************
    localparam logic [14:0] CFG_RESET  = 15'h0000;
    localparam logic [7:0]  TYPE_RESET = 8'h00;

    typedef enum logic [2:0] {
        AEWC_MODE_NONE  = 3'b001,
        AEWC_MODE_BIDIR = 3'b010,
        AEWC_MODE_SYNC  = 3'b100
    } aewc_mode_type;

endpackage

// *** verilog/aewc_pos_fmt.sv ***
// Position frame formatter: width mask, coding conversion and turn split.
`timescale 1ns/10ps
module aewc_pos_fmt #(
    parameter int POS_W = 32
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               frame_valid,
    input  wire logic [POS_W-1:0]   frame_data,
    input  wire logic [7:0]         total_bits,
    input  wire logic [6:0]         turn_bits,
    input  wire logic               gray_in,
    output logic                    pos_valid_q,
    output logic [POS_W-1:0]        pos_q,
    output logic [POS_W-1:0]        turns_q
);

    logic [POS_W-1:0] mask;
    logic [POS_W-1:0] masked;
    logic [POS_W-1:0] from_gray;
    logic [POS_W-1:0] value;
    logic [7:0]       single_bits;
    logic             pos_valid_d;
    logic [POS_W-1:0] pos_d;
    logic [POS_W-1:0] turns_d;

    // Bits above the programmed width are forced to zero, so a long frame
    // from a misconfigured encoder cannot leak stale high bits.
    genvar i;
    generate
        for (i = 0; i < POS_W; i++) begin : g_bit
            assign mask[i]      = (8'(i) < total_bits);
            assign masked[i]    = frame_data[i] & mask[i];
            assign from_gray[i] = ^masked[POS_W-1:i];
        end
    endgenerate

    always_comb begin
        value       = gray_in ? from_gray : masked;
        single_bits = (total_bits > {1'b0, turn_bits}) ?
                      8'(total_bits - {1'b0, turn_bits}) : 8'h00;
        pos_valid_d = frame_valid;
        pos_d       = frame_valid ? value : pos_q;
        turns_d     = frame_valid ? (value >> single_bits) : turns_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_valid_q <= 1'b0;
            pos_q       <= '0;
            turns_q     <= '0;
        end else begin
            pos_valid_q <= pos_valid_d;
            pos_q       <= pos_d;
            turns_q     <= turns_d;
        end
    end

endmodule // aewc_pos_fmt

// *** verilog/aewc_top.sv ***
// Absolute encoder width configuration block with its APB register slave.
`timescale 1ns/10ps
module aewc_top #(
    parameter int POS_W = 32
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    input  wire logic               frame_valid,
    input  wire logic [POS_W-1:0]   frame_data,
    output logic                    pos_valid,
    output logic [POS_W-1:0]        pos_raw,
    output logic [POS_W-1:0]        pos_turns,
    output logic [7:0]              enc_total_bits,
    output logic [6:0]              enc_turn_bits,
    output logic                    enc_binary
);

    // ************************************************************
    // APB access and register state.
    // ************************************************************
    logic                      pready_q, pready_d;
    logic [31:0]               prdata_q, prdata_d;
    logic                      pslverr_q, pslverr_d;
    logic [14:0]               cfg_q, cfg_d;
    logic [7:0]                axis_type_select_q, axis_type_select_d;
    aewc_pkg::aewc_mode_type   mode_q, mode_d;
    logic [7:0]                total_q, total_d;
    logic [6:0]                mturn_q, mturn_d;
    logic                      binary_q, binary_d;
    logic                      access;
    logic                      done;
    logic                      wr_done;
    logic                      mapped;
    logic                      type_wr;
    logic                      gray_sel;
    logic [31:0]               status_word;

    // All checks below run on the bus clock and sleep during reset.
    default clocking chk_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // The slave answers in the second access cycle; the first access cycle
    // gives a registered read path with no combinational bus output.
    assign access  = psel & penable;
    assign done    = access & pready_q;
    assign wr_done = done & pwrite;
    assign mapped  = (paddr == aewc_pkg::ADDR_WIDTH_CFG) ||
                     (paddr == aewc_pkg::ADDR_AXIS_TYPE) ||
                     (paddr == aewc_pkg::ADDR_STATUS)    ||
                     (paddr == aewc_pkg::ADDR_POSITION)  ||
                     (paddr == aewc_pkg::ADDR_TURNS);
    assign type_wr = wr_done && (paddr == aewc_pkg::ADDR_AXIS_TYPE);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[aewc_pkg::TOTAL_LSB +: aewc_pkg::TOTAL_W] = total_q;
        status_word[aewc_pkg::MTURN_LSB +: aewc_pkg::MTURN_W] = mturn_q;
        status_word[aewc_pkg::STAT_BIN_BIT]                   = binary_q;
        status_word[aewc_pkg::STAT_MODE_LSB +: 3]             = mode_q;
    end

    always_comb begin
        pready_d  = access & ~pready_q;
        pslverr_d = access & ~pready_q & ~mapped;
        prdata_d  = 32'h0000_0000;
        if (access && !pready_q && !pwrite) begin
            case (paddr)
                aewc_pkg::ADDR_WIDTH_CFG: prdata_d = {17'h0_0000, cfg_q};
                aewc_pkg::ADDR_AXIS_TYPE:
                    prdata_d = {24'h00_0000, axis_type_select_q};
                aewc_pkg::ADDR_STATUS:    prdata_d = status_word;
                aewc_pkg::ADDR_POSITION:  prdata_d = 32'(pos_raw);
                aewc_pkg::ADDR_TURNS:     prdata_d = 32'(pos_turns);
                default:                  prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // Width word and axis type decode.
    // ************************************************************
    // Software must store the width word before choosing the axis type;
    // a word written later only takes effect at the next type write.
    always_comb begin
        cfg_d              = cfg_q;
        axis_type_select_d = axis_type_select_q;
        mode_d             = mode_q;
        total_d            = total_q;
        mturn_d            = mturn_q;
        binary_d           = binary_q;
        if (wr_done && paddr == aewc_pkg::ADDR_WIDTH_CFG) begin
            cfg_d = pwdata[aewc_pkg::CFG_W-1:0];
        end
        if (type_wr) begin
            axis_type_select_d = pwdata[7:0];
            case (pwdata[7:0])
                aewc_pkg::TYPE_BIDIR_ABS: begin
                    mode_d   = aewc_pkg::AEWC_MODE_BIDIR;
                    total_d  = cfg_q[aewc_pkg::TOTAL_LSB +:
                                     aewc_pkg::TOTAL_W];
                    mturn_d  = cfg_q[aewc_pkg::MTURN_LSB +:
                                     aewc_pkg::MTURN_W];
                    binary_d = 1'b1;
                end
                aewc_pkg::TYPE_SYNC_ABS: begin
                    mode_d   = aewc_pkg::AEWC_MODE_SYNC;
                    total_d  = {2'b00, cfg_q[aewc_pkg::SYNC_BITS_W-1:0]};
                    mturn_d  = 7'h00;
                    binary_d = cfg_q[aewc_pkg::SYNC_BIN_BIT];
                end
                default: begin
                    mode_d   = aewc_pkg::AEWC_MODE_NONE;
                    total_d  = 8'h00;
                    mturn_d  = 7'h00;
                    binary_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q           <= 1'b0;
            prdata_q           <= 32'h0000_0000;
            pslverr_q          <= 1'b0;
            cfg_q              <= aewc_pkg::CFG_RESET;
            axis_type_select_q <= aewc_pkg::TYPE_RESET;
            mode_q             <= aewc_pkg::AEWC_MODE_NONE;
            total_q            <= 8'h00;
            mturn_q            <= 7'h00;
            binary_q           <= 1'b1;
        end else begin
            pready_q           <= pready_d;
            prdata_q           <= prdata_d;
            pslverr_q          <= pslverr_d;
            cfg_q              <= cfg_d;
            axis_type_select_q <= axis_type_select_d;
            mode_q             <= mode_d;
            total_q            <= total_d;
            mturn_q            <= mturn_d;
            binary_q           <= binary_d;
        end
    end

    assign pready         = pready_q;
    assign prdata         = prdata_q;
    assign pslverr        = pslverr_q;
    assign enc_total_bits = total_q;
    assign enc_turn_bits  = mturn_q;
    assign enc_binary     = binary_q;

    // ************************************************************
    // Position frames.
    // ************************************************************
    // Gray decode applies only to the synchronous type with coding bit low.
    assign gray_sel = (mode_q == aewc_pkg::AEWC_MODE_SYNC) & ~binary_q;

    aewc_pos_fmt #(
        .POS_W       (POS_W)
    ) u_fmt (
        .pclk        (pclk),
        .presetn     (presetn),
        .frame_valid (frame_valid & (mode_q != aewc_pkg::AEWC_MODE_NONE)),
        .frame_data  (frame_data),
        .total_bits  (total_q),
        .turn_bits   (mturn_q),
        .gray_in     (gray_sel),
        .pos_valid_q (pos_valid),
        .pos_q       (pos_raw),
        .turns_q     (pos_turns)
    );

    // ************************************************************
    // Assertions.
    // ************************************************************
    sequence type_write_s(logic [7:0] code);
        type_wr && pwdata[7:0] == code;
    endsequence

    ignore_type_a: assert property (
        type_wr && pwdata[7:0] != aewc_pkg::TYPE_BIDIR_ABS &&
        pwdata[7:0] != aewc_pkg::TYPE_SYNC_ABS |=>
        mode_q == aewc_pkg::AEWC_MODE_NONE && total_q == 8'h00)
        else $error("other axis type did not clear the widths");

    bidir_total_a: assert property (
        type_write_s(aewc_pkg::TYPE_BIDIR_ABS) |=>
        total_q == $past(cfg_q[7:0]))
        else $error("bidirectional total width not taken from word");

    bidir_turns_a: assert property (
        type_write_s(aewc_pkg::TYPE_BIDIR_ABS) |=>
        mturn_q == $past(cfg_q[14:8]))
        else $error("multi-turn width not taken from word");

    sync_total_a: assert property (
        type_write_s(aewc_pkg::TYPE_SYNC_ABS) |=>
        total_q == {2'b00, $past(cfg_q[5:0])} && mturn_q == 7'h00)
        else $error("synchronous width not taken from low six bits");

    sync_coding_a: assert property (
        type_write_s(aewc_pkg::TYPE_SYNC_ABS) |=>
        binary_q == $past(cfg_q[6]))
        else $error("coding select not taken from bit six");

    // The mask in force is the one that stood when the frame was taken, so
    // a type write in the same cycle does not trip this check.
    pos_width_a: assert property (
        frame_valid && mode_q != aewc_pkg::AEWC_MODE_NONE &&
        total_q < 8'(POS_W) |=>
        pos_valid && (pos_raw >> $past(total_q)) == '0)
        else $error("position wider than programmed width");

    fields_hold_a: assert property (
        !type_wr |=> $stable(total_q) && $stable(mturn_q) &&
        $stable(binary_q))
        else $error("decoded fields changed without a type write");

    apb_answer_a: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("slave did not answer after one wait cycle");

endmodule // aewc_top

// *** testbench/aewc_enc_model.sv ***
// Behavioural absolute encoder that hands frames to the block.
`timescale 1ns/10ps
module aewc_enc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        send,
    input  wire logic [31:0] value,
    input  wire logic [3:0]  delay,
    output logic             frame_valid,
    output logic [31:0]      frame_data
);
    logic [3:0]  cnt_q;
    logic        busy_q;
    logic [31:0] hold_q;
    // Outside a frame the data lines toggle every cycle, so a stale value
    // is never mistaken for a fresh one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q       <= 4'h0;
            busy_q      <= 1'b0;
            hold_q      <= 32'h0000_0000;
            frame_valid <= 1'b0;
            frame_data  <= 32'h0000_0000;
        end else begin
            frame_valid <= 1'b0;
            frame_data  <= ~frame_data;
            if (send) begin
                busy_q <= 1'b1;
                cnt_q  <= delay;
                hold_q <= value;
            end else if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    frame_valid <= 1'b1;
                    frame_data  <= hold_q;
                    busy_q      <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
        end
    end
endmodule // aewc_enc_model

// *** testbench/aewc_bench.sv ***
// Self-checking bench for the encoder width configuration block.
`timescale 1ns/10ps
module aewc_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, pos_raw, pos_turns, fdata, fval, rd;
    logic        fvalid, pos_valid, enc_binary, send, er;
    logic [3:0]  fdelay;
    logic [7:0]  enc_total_bits;
    logic [6:0]  enc_turn_bits;
    logic [7:0]  other_types [3] = '{8'h05, 8'h2E, 8'h31};
    int          err_count, checked;

    aewc_top #(.POS_W(32)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .frame_valid(fvalid), .frame_data(fdata),
        .pos_valid(pos_valid), .pos_raw(pos_raw), .pos_turns(pos_turns),
        .enc_total_bits(enc_total_bits), .enc_turn_bits(enc_turn_bits),
        .enc_binary(enc_binary));
    aewc_enc_model enc (.pclk(pclk), .presetn(presetn), .send(send),
        .value(fval), .delay(fdelay), .frame_valid(fvalid),
        .frame_data(fdata));

    // ************************************************************
    // Bus, frame and compare tasks.
    // ************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t output %h expected %h", $time, got, exp);
        end
    endtask
    // The request stands until the rising edge at which pready is seen high;
    // read data are taken at that edge and only then is the bus released.
    // No wait count is assumed: only the watchdog ends a stuck transfer.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input logic [31:0] v, input logic [3:0] dl,
                         output int hits);
        int n;
        hits = 0;
        @(posedge pclk);
        send   <= 1'b1;
        fval   <= v;
        fdelay <= dl;
        @(posedge pclk);
        send <= 1'b0;
        for (n = 0; n < 12; n++) begin
            @(negedge pclk);
            if (pos_valid === 1'b1) hits++;
            if (hits > 0) break;
        end
    endtask
    task automatic set_axis(input logic [31:0] w, input logic [7:0] t);
        apb(1'b1, aewc_pkg::ADDR_WIDTH_CFG, w);
        apb(1'b1, aewc_pkg::ADDR_AXIS_TYPE, {24'h00_0000, t});
    endtask

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim();
    end

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        int h;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0000_0000; send = 1'b0;
        fval = 32'h0000_0000; fdelay = 4'h0; err_count = 0; checked = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, aewc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk_reg(rd, 32'h0101_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk_reg({er, rd[30:0]}, 32'h8000_0000);
        $display("test reset done");

        set_axis(32'h0000_0C19, aewc_pkg::TYPE_BIDIR_ABS);
        apb(1'b0, aewc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk_reg(rd, 32'h0201_0C19);
        chk_out(32'(enc_total_bits), 32'h0000_0019);
        chk_out(32'(enc_turn_bits), 32'h0000_000C);
        frame(32'hFFFF_FFFF, 4'h0, h);
        chk_out(h, 32'h0000_0001);
        chk_out(pos_raw, 32'h01FF_FFFF);
        chk_out(pos_turns, 32'h0000_0FFF);
        apb(1'b1, aewc_pkg::ADDR_WIDTH_CFG, 32'h0000_0000);
        frame(32'h8765_4321, 4'h5, h);
        chk_out(pos_raw, 32'h0165_4321);
        apb(1'b0, aewc_pkg::ADDR_TURNS, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0B2A);
        apb(1'b0, aewc_pkg::ADDR_POSITION, 32'h0000_0000);
        chk_reg(rd, 32'h0165_4321);
        $display("test bidirectional type done");

        set_axis(32'h0000_7F4C, aewc_pkg::TYPE_SYNC_ABS);
        apb(1'b0, aewc_pkg::ADDR_WIDTH_CFG, 32'h0000_0000);
        chk_reg(rd, 32'h0000_7F4C);
        apb(1'b0, aewc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk_reg(rd, 32'h0401_000C);
        frame(32'hABCD_E123, 4'h0, h);
        chk_out(pos_raw, 32'h0000_0123);
        chk_out(pos_turns, 32'h0000_0000);
        set_axis(32'h0000_000C, aewc_pkg::TYPE_SYNC_ABS);
        // The type write lands at the edge the task returns on; let it settle.
        @(negedge pclk);
        chk_out({31'h0, enc_binary}, 32'h0000_0000);
        frame(32'hFFFF_F003, 4'h3, h);
        chk_out(pos_raw, 32'h0000_0002);
        $display("test synchronous type done");

        // Other types must clear the decode even with every width bit set.
        for (int i = 0; i < 3; i++) begin
            set_axis(32'h0000_7FFF, other_types[i]);
            apb(1'b0, aewc_pkg::ADDR_STATUS, 32'h0000_0000);
            chk_reg(rd, 32'h0101_0000);
        end
        frame(32'h1234_5678, 4'h0, h);
        chk_out(h, 32'h0000_0000);
        $display("test other types done");

        // A reset in mid-run must bring back every value after reset.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_out(pos_raw, 32'h0000_0000);
        apb(1'b0, aewc_pkg::ADDR_WIDTH_CFG, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0000);
        apb(1'b0, aewc_pkg::ADDR_AXIS_TYPE, 32'h0000_0000);
        chk_reg(rd, 32'h0000_0000);
        apb(1'b0, aewc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk_reg(rd, 32'h0101_0000);
        $display("test mid reset done");
        end_sim();
    end
endmodule // aewc_bench
